// ===== hw/ufsc_pkg.sv
// Constants for the usage fault status capture block
//
// Notes on behaviour
// - Divide with zero divisor sets flag bit 25 when divide trapping enabled.
// - Only the divide trap enable bit permits it; clear enable keeps flag 0.
// - Divide fault stacks return PC of the faulting divide instruction.
// - Misaligned access sets flag bit 24 when misaligned trapping enabled.
// - Ordinary loads/stores trap misaligned only with dedicated enable bit.
// - Misaligned multiple and doubleword transfers always fault.
// - Bits 23:20 read-only, read zero; software preserves them.
// - Any coprocessor access attempt sets flag bit 19 as usage fault.
// - Illegal return-code load to PC sets flag bit 18.
// - Invalid return load stacks PC of the offending instruction unless another cause fires in the same cycle.
// - Each flag clears when software writes one to its bit, unless its cause sets it in the same cycle.
// - Status half sits at bits 31:16; also halfword access at 0xD2A.
// - Register access allowed only in privileged mode.
package ufsc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] FSR_OFFSET = 12'hd28;
   localparam logic [11:0] USH_OFFSET = 12'hd2a;
   localparam logic [31:0] FSR_RESET = 32'h0000_0000;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int DZ_FLAG_BIT = 25;
   localparam int MISAL_BIT = 24;
   localparam int COPROC_FLAG_BIT = 19;
   localparam int INVRET_BIT = 18;
   localparam int HALF_LSB = 16;
   // Access sizes
   typedef enum logic [1:0] {
      UFSC_SZ_BYTE,
      UFSC_SZ_HALF,
      UFSC_SZ_WORD
   } ufsc_size_t;
endpackage : ufsc_pkg

// ===== hw/ufsc_flag.sv
// One sticky write-one-to-clear fault flag
`timescale 1ns/1ps
module ufsc_flag (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_ev,
   input wire logic clr_ev,
   output logic flag
);
   logic flag_r;
   logic flag_nxt;

   always_comb begin
      flag_nxt = flag_r;
      if (clr_ev) begin
         flag_nxt = 1'b0;
      end
      if (set_ev) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;
endmodule : ufsc_flag

// ===== hw/ufsc_top.sv
// Usage fault status capture: sticky causes, privileged register port
`timescale 1ns/1ps
module ufsc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic div_exec,
   input wire logic div_zero,
   input wire logic [31:0] div_pc,
   input wire logic div_trap_en,
   input wire logic mem_misaligned,
   input wire logic mem_multi_or_dbl,
   input wire logic [31:0] mem_pc,
   input wire logic misal_trap_en,
   input wire logic cop_access,
   input wire logic [31:0] cop_pc,
   input wire logic ret_load_bad,
   input wire logic [31:0] ret_pc,
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [11:0] reg_addr,
   input wire logic [1:0] reg_size,
   input wire logic reg_priv,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_err,
   output logic fault_req,
   output logic [31:0] stacked_pc
);
   // ------------------------------------------------------------
   // Fault causes
   // ------------------------------------------------------------
   logic div_fault;
   logic misal_fault;
   logic [3:0] set_vec;
   logic [3:0] clr_vec;
   logic [3:0] flags;
   logic [31:0] wmask;
   logic acc_ok;
   logic [31:0] status;
   logic [31:0] rdata_r;
   logic err_r;
   logic fault_r;
   logic [31:0] pc_r;

   assign div_fault = div_exec & div_zero & div_trap_en;
   // Multiple/doubleword bypass the enable
   assign misal_fault = mem_misaligned &
      (misal_trap_en | mem_multi_or_dbl);

   assign set_vec = {div_fault, misal_fault, cop_access,
      ret_load_bad};

   // ------------------------------------------------------------
   // Register access decode
   // ------------------------------------------------------------
   function automatic logic [31:0] lane_mask(input logic [11:0] a,
                                             input logic [1:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      if (a == ufsc_pkg::FSR_OFFSET &&
          s == ufsc_pkg::UFSC_SZ_WORD) begin
         m = 32'hffff_ffff;
      end else if (a == ufsc_pkg::USH_OFFSET &&
                   s == ufsc_pkg::UFSC_SZ_HALF) begin
         m = 32'hffff_0000;
      end else if (a == ufsc_pkg::FSR_OFFSET &&
                   s == ufsc_pkg::UFSC_SZ_HALF) begin
         m = 32'h0000_ffff;
      end else if ((a == ufsc_pkg::FSR_OFFSET ||
                    a == 12'hd29 || a == ufsc_pkg::USH_OFFSET ||
                    a == 12'hd2b) && s == ufsc_pkg::UFSC_SZ_BYTE) begin
         m = 32'h0000_00ff << {a[1:0], 3'b000};
      end
      return m;
   endfunction : lane_mask

   assign acc_ok = reg_sel & reg_priv;
   // Halfword at the upper offset carries data in low lanes
   assign wmask = lane_mask(reg_addr, reg_size);

   logic [31:0] wdata_al;
   always_comb begin
      wdata_al = reg_wdata;
      if (reg_size != ufsc_pkg::UFSC_SZ_WORD) begin
         wdata_al = reg_wdata << {reg_addr[1:0], 3'b000};
      end
   end

   assign clr_vec = (acc_ok & reg_wr && wmask != 32'h0000_0000) ?
      {wdata_al[ufsc_pkg::DZ_FLAG_BIT] & wmask[ufsc_pkg::DZ_FLAG_BIT],
       wdata_al[ufsc_pkg::MISAL_BIT] & wmask[ufsc_pkg::MISAL_BIT],
       wdata_al[ufsc_pkg::COPROC_FLAG_BIT] &
          wmask[ufsc_pkg::COPROC_FLAG_BIT],
       wdata_al[ufsc_pkg::INVRET_BIT] & wmask[ufsc_pkg::INVRET_BIT]}
      : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         ufsc_flag u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .set_ev(set_vec[gi]),
            .clr_ev(clr_vec[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate

   // Reserved and uncovered bits read zero
   always_comb begin
      status = ufsc_pkg::FSR_RESET;
      status[ufsc_pkg::DZ_FLAG_BIT] = flags[3];
      status[ufsc_pkg::MISAL_BIT] = flags[2];
      status[ufsc_pkg::COPROC_FLAG_BIT] = flags[1];
      status[ufsc_pkg::INVRET_BIT] = flags[0];
   end

   // ------------------------------------------------------------
   // Read port, registered one cycle
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else begin
         err_r <= reg_sel & (~reg_priv |
            (lane_mask(reg_addr, reg_size) == 32'h0000_0000));
         if (acc_ok && !reg_wr) begin
            rdata_r <= (status & wmask) >> {reg_addr[1:0], 3'b000};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Fault request and stacked return PC
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_r <= 1'b0;
         pc_r <= 32'h0000_0000;
      end else begin
         fault_r <= |set_vec;
         // Earliest cause in priority order names the PC
         if (div_fault) begin
            pc_r <= div_pc;
         end else if (misal_fault) begin
            pc_r <= mem_pc;
         end else if (cop_access) begin
            pc_r <= cop_pc;
         end else if (ret_load_bad) begin
            pc_r <= ret_pc;
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_err = err_r;
   assign fault_req = fault_r;
   assign stacked_pc = pc_r;
endmodule : ufsc_top

// ===== bench/ufsc_proc_model.sv
// Model of the processor side that raises usage fault causes
`timescale 1ns/1ps
module ufsc_proc_model (
   input wire logic clk,
   output logic dex, dz, mis, mul, cop, ret,
   output logic [31:0] pc
);
   // ------------------------------------------------------------
   // Cause pulses
   // ------------------------------------------------------------
   initial {dex, dz, mis, mul, cop, ret, pc} = '0;
   // One cycle per cause; PC inverted after so stale values never match
   task automatic raise(input logic [5:0] ev, input logic [31:0] p);
      @(posedge clk);
      #1 {dex, dz, mis, mul, cop, ret} = ev;
      pc = p;
      @(posedge clk);
      #1 {dex, dz, mis, mul, cop, ret} = '0;
      pc = ~p;
   endtask : raise
endmodule : ufsc_proc_model

// ===== bench/ufsc_checker.sv
// Port checker for the usage fault status capture block
`timescale 1ns/1ps
module ufsc_checker (
   input wire logic clk, rst_n, div_exec, div_zero, div_trap_en,
   input wire logic mem_misaligned, mem_multi_or_dbl, misal_trap_en,
   input wire logic cop_access, ret_load_bad, reg_sel, reg_wr, reg_priv,
   input wire logic [31:0] div_pc, mem_pc, cop_pc, ret_pc, reg_wdata,
   input wire logic [11:0] reg_addr,
   input wire logic [1:0] reg_size,
   input wire logic [31:0] reg_rdata, stacked_pc,
   input wire logic reg_err, fault_req
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic dv = div_exec && div_zero && div_trap_en;
   wire logic ms = mem_misaligned && (misal_trap_en || mem_multi_or_dbl);
   property p_div; dv |=> fault_req && stacked_pc == $past(div_pc);
   endproperty
   a_div: assert property (p_div)
      else $error("divide fault missed");
   property p_cause; fault_req |-> $past(dv || ms || cop_access ||
      ret_load_bad); endproperty
   a_cause: assert property (p_cause)
      else $error("fault without cause");
   property p_multi; mem_misaligned && mem_multi_or_dbl |=> fault_req;
   endproperty
   a_multi: assert property (p_multi)
      else $error("multiple transfer fault missed");
   property p_mis; ms && !dv |=> stacked_pc == $past(mem_pc); endproperty
   a_mis: assert property (p_mis)
      else $error("misaligned pc wrong");
   property p_cop; cop_access |=> fault_req; endproperty
   a_cop: assert property (p_cop)
      else $error("coprocessor fault missed");
   property p_ret; ret_load_bad && !dv && !ms && !cop_access |=>
      fault_req && stacked_pc == $past(ret_pc); endproperty
   a_ret: assert property (p_ret)
      else $error("return load pc wrong");
   property p_err; reg_sel && !reg_priv |=> reg_err && reg_rdata == 0;
   endproperty
   a_err: assert property (p_err)
      else $error("unprivileged access not refused");
   property p_rsv; reg_sel && reg_priv && !reg_wr && reg_addr == 12'hd2a
      && reg_size == 2'h1 |=> !reg_err && reg_rdata[7:4] == 4'h0;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bits not zero");
endmodule : ufsc_checker
bind ufsc_top ufsc_checker chk (.*);

// ===== bench/test_usage_fault_status_capture.sv
// Testbench for the usage fault status capture block
`timescale 1ns/1ps
module test_usage_fault_status_capture;
   logic clk = 0, rst_n = 0, div_trap_en = 0, misal_trap_en = 0;
   logic reg_sel = 0, reg_wr = 0, reg_priv = 1, reg_err, fault_req;
   logic div_exec, div_zero, mem_misaligned, mem_multi_or_dbl;
   logic cop_access, ret_load_bad;
   logic [11:0] reg_addr = 0;
   logic [1:0] reg_size = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, stacked_pc, pc;
   wire [31:0] div_pc = pc, mem_pc = pc, cop_pc = pc, ret_pc = pc;
   int bad_count = 0, samples_checked = 0;
   always #50 clk = ~clk;
   ufsc_proc_model pm (.clk(clk), .dex(div_exec), .dz(div_zero),
      .mis(mem_misaligned), .mul(mem_multi_or_dbl), .cop(cop_access),
      .ret(ret_load_bad), .pc(pc));
   ufsc_top uut (.*);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic cmp(string n, logic [31:0] s, logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic acc(logic w, logic p, logic [11:0] a, logic [1:0] z,
      logic [31:0] d, logic [31:0] e, logic er);
      // Drive just after an edge so back-to-back calls never collide
      @(posedge clk);
      #1 {reg_sel, reg_wr, reg_priv, reg_addr, reg_size, reg_wdata} =
         {1'b1, w, p, a, z, d};
      @(posedge clk);
      #1 reg_sel = 0;
      cmp("rdata", reg_rdata, e);
      cmp("err", {31'h0, reg_err}, {31'h0, er});
   endtask : acc
   // Raise a cause, check the request, then read the status half
   task automatic ev(logic [5:0] e, logic [31:0] h, logic q);
      pm.raise(e, 32'h100 + e);
      cmp("req", {31'h0, fault_req}, {31'h0, q});
      if (q) cmp("pc", stacked_pc, 32'h100 + e);
      acc(0, 1, 12'hd2a, 2'h1, 0, h, 0);
   endtask : ev
   task end_of_test;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      acc(0, 1, 12'hd2a, 2'h1, 0, 0, 0);
      ev(6'h30, 0, 0);
      div_trap_en = 1;
      ev(6'h30, 32'h200, 1);
      misal_trap_en = 1;
      ev(6'h08, 32'h300, 1);
      acc(1, 1, 12'hd2a, 2'h1, 0, 0, 0);
      acc(1, 1, 12'hd2a, 2'h1, 32'h100, 0, 0);
      misal_trap_en = 0;
      ev(6'h08, 32'h200, 0);
      ev(6'h0c, 32'h300, 1);
      ev(6'h02, 32'h308, 1);
      ev(6'h01, 32'h30c, 1);
      acc(0, 1, 12'hd28, 2'h2, 0, 32'h030c_0000, 0);
      acc(1, 0, 12'hd2a, 2'h1, 32'hffff, 0, 1);
      acc(0, 1, 12'hd30, 2'h2, 0, 0, 1);
      fork
         pm.raise(6'h02, 32'h40);
         acc(1, 1, 12'hd2a, 2'h1, 32'h8, 0, 0);
      join
      acc(0, 1, 12'hd2a, 2'h1, 0, 32'h30c, 0);
      end_of_test;
   end
endmodule : test_usage_fault_status_capture
